// ---- rtl/arm_consts.svh ----
/*
  shared constants of the arming output stage and the dual spi front.
  assumes it is included by the package and by every design module.
*/
`ifndef ARM_CONSTS_SVH
`define ARM_CONSTS_SVH
`define AXES 2
`define FRAME_W 16
`define CNT_W 4
`define SMP_W 10
`define TH_W 8
`define TMR_W 8
`define BIT_ACC 15
`define BIT_AXIS 14
`define ADDR_LSB 8
`define ACC_HDR 4'h0
`define REG_FILL 8'h00
`define ERR_WORD 16'h8000
`define CMD_RESET 16'hFFFF
`define MODE_MA 2'h0
`define MODE_CNT 2'h1
`define MODE_UNF 2'h2
`define MODE_PCM 2'h3
`define SEL_OFF 2'h0
`define SEL_T1 2'h1
`define SEL_T2 2'h2
`define SEL_T3 2'h3
`define STRETCH_1 8'h10
`define STRETCH_2 8'h20
`define STRETCH_3 8'h40
`define SYS_MHZ 200
`define SYS_CLK_NS 5
`define INIT_NS 10000
`define INIT_W 12
`define INIT_CYCLES ((`INIT_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define TICK_NS 100000
`define TICK_W 16
`define TICK_CYCLES (`TICK_NS / `SYS_CLK_NS)
`define PCM_MHZ 8
`define PCM_W 5
`define PCM_CODE_W 9
`define PCM_CYCLES (`SYS_MHZ / `PCM_MHZ)
`endif

// ---- rtl/arm_pkg.sv ----
/*
  types of the arming output stage and the dual spi front.
  assumes arm_consts.svh sits beside it.
*/
`include "arm_consts.svh"
package arm_pkg;
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_IDLE = 3'h2,
        ST_FRAME = 3'h4
    } phase_t;
    typedef struct packed {
        logic [`TH_W-1:0] pos;
        logic [`TH_W-1:0] neg;
    } thresh_t;
    typedef struct packed {
        logic [1:0] mode;
        logic active_low;
    } arm_field_t;
    typedef struct packed {
        logic [1:0] x_stretch_select;
        logic [1:0] y_stretch_select;
    } arm_config_t;
    typedef struct packed {
        logic [`FRAME_W-1:0] rx;
        logic [`CNT_W-1:0] cnt;
    } lane_state_t;
    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic uv_meta;
        logic uv_sync;
        phase_t phase;
        logic [`INIT_W-1:0] init_cnt;
        logic [`TICK_W-1:0] tick_cnt;
        logic [`FRAME_W-1:0] tx_word;
        logic tx_own_y;
        logic tx_valid;
        logic pend_acc;
        logic pend_axis;
        logic acc_resp;
        logic resp_axis;
        logic [`AXES-1:0] cond;
        logic [`AXES-1:0][`TMR_W-1:0] tmr;
        logic [`PCM_W-1:0] pcm_cnt;
        logic [`AXES-1:0][`PCM_CODE_W-1:0] pcm_acc;
        logic [`AXES-1:0] pcm;
        logic [`AXES-1:0] pin;
    } front_state_t;
endpackage

// ---- rtl/spi_lane.sv ----
/*
  one serial interface block: own shift register on the link clock.
  assumes frames of 16 clocks and a response word held stable over a frame.
*/
`timescale 1ns/100ps
`include "arm_consts.svh"
module spi_lane (
    // link side
    input wire logic sclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic mosi,
    // response from the system side
    input wire logic [`FRAME_W-1:0] tx_word,
    input wire logic tx_en,
    // captured frame and serial out
    output logic [`FRAME_W-1:0] rx_frame,
    output logic miso_bit,
    output logic miso_oe
);
    arm_pkg::lane_state_t q;
    arm_pkg::lane_state_t d;

    // ----------------------------------------
    // shift on rising clock, msb first
    // ----------------------------------------
    always_comb begin
        d = q;
        if (!cs_n) begin
            d.rx = {q.rx[`FRAME_W-2:0], mosi};
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rx_frame = q.rx;
    assign miso_bit = tx_word[~q.cnt];
    assign miso_oe = tx_en & ~cs_n;

    AST_LANE_HOLD: assert property (@(posedge sclk) disable iff (!reset_n)
        cs_n |=> (q == $past(q)))
        else $error("lane shifted while select inactive");
endmodule

// ---- rtl/arming_output_and_spi_front.sv ----
/*
  arming evaluation, pulse stretch, pin polarity, pulse-code output and
  the duplicated spi front with frame compare.
  assumes samples, thresholds, configuration and filter outcomes come
  from logic on sys_clk; cs_n, sclk, mosi and undervolt come from pins.
*/
`timescale 1ns/100ps
`include "arm_consts.svh"
module arming_output_and_spi_front #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic undervolt,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // configuration
    input wire arm_pkg::arm_field_t arm_field,
    input wire arm_pkg::arm_config_t arm_config,
    input wire arm_pkg::thresh_t x_arming_thresholds,
    input wire arm_pkg::thresh_t y_arming_thresholds,
    // samples and filter outcomes
    input wire logic [`SMP_W-1:0] x_sample,
    input wire logic [`SMP_W-1:0] y_sample,
    input wire logic [`AXES-1:0] filt_hit,
    input wire logic exception_flag,
    // arming pins
    output logic arm_x_pin,
    output logic arm_y_pin
);
    arm_pkg::front_state_t q;
    arm_pkg::front_state_t d;

    logic [`AXES-1:0][`FRAME_W-1:0] rx_frame;
    logic [`AXES-1:0] lane_bit;
    logic [`AXES-1:0] lane_oe;
    logic [`AXES-1:0][`SMP_W-1:0] sample;
    arm_pkg::thresh_t [`AXES-1:0] thr;
    logic [`AXES-1:0][1:0] sel;
    logic [`FRAME_W-1:0] x_rx;
    logic [`FRAME_W-1:0] y_rx;
    logic cs_fall;
    logic cs_rise;
    logic tick;
    logic pcm_strobe;
    logic mismatch;
    logic filt_mode;
    logic unf_mode;
    logic [`AXES-1:0] eval;
    logic [`AXES-1:0] active;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic thr_hit(
        input logic [`SMP_W-1:0] s,
        input arm_pkg::thresh_t t
    );
        logic [`TH_W-1:0] v;
        v = s[`SMP_W-1 -: `TH_W];
        return ($signed(v) >= $signed(t.pos)) || ($signed(v) <= $signed(t.neg));
    endfunction

    function automatic logic [`TMR_W-1:0] stretch_load(input logic [1:0] s);
        logic [`TMR_W-1:0] v;
        unique case (s)
            `SEL_OFF: v = '0;
            `SEL_T1: v = `STRETCH_1;
            `SEL_T2: v = `STRETCH_2;
            `SEL_T3: v = `STRETCH_3;
        endcase
        return v;
    endfunction

    function automatic logic [`PCM_CODE_W-1:0] pcm_code(input logic [`SMP_W-1:0] s);
        return {~s[`SMP_W-1], s[`SMP_W-2:1]};
    endfunction

    // ----------------------------------------
    // per-axis wiring and the two interface blocks
    // ----------------------------------------
    assign sample = {y_sample, x_sample};
    assign thr = {y_arming_thresholds, x_arming_thresholds};
    assign sel = {arm_config.y_stretch_select, arm_config.x_stretch_select};
    assign x_rx = rx_frame[0];
    assign y_rx = rx_frame[1];

    generate
        for (genvar g = 0; g < `AXES; g++) begin : g_lane
            spi_lane u_lane (
                .sclk(sclk),
                .reset_n(reset_n),
                .cs_n(cs_n),
                .mosi(mosi),
                .tx_word(q.tx_word),
                .tx_en(q.tx_valid & (q.tx_own_y == 1'(g))),
                .rx_frame(rx_frame[g]),
                .miso_bit(lane_bit[g]),
                .miso_oe(lane_oe[g])
            );
        end
    endgenerate

    assign miso = |(lane_bit & lane_oe);
    assign miso_oe = |lane_oe;
    assign arm_x_pin = q.pin[0];
    assign arm_y_pin = q.pin[1];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        active = '0;
        eval = '0;
        cs_fall = q.cs_prev & ~q.cs_sync;
        cs_rise = ~q.cs_prev & q.cs_sync;
        tick = (q.tick_cnt == `TICK_W'(TICK_CYCLES - 1));
        pcm_strobe = (q.pcm_cnt == `PCM_W'(`PCM_CYCLES - 1));
        mismatch = (x_rx != y_rx);
        filt_mode = (arm_field.mode == `MODE_MA) || (arm_field.mode == `MODE_CNT);
        unf_mode = (arm_field.mode == `MODE_UNF);

        // pin synchronisers
        d.cs_meta = cs_n;
        d.cs_sync = q.cs_meta;
        d.cs_prev = q.cs_sync;
        d.uv_meta = undervolt;
        d.uv_sync = q.uv_meta;

        // time bases
        d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
        d.pcm_cnt = pcm_strobe ? '0 : q.pcm_cnt + 1'b1;

        unique case (q.phase)
            arm_pkg::ST_INIT: begin
                d.cond = '0;
                d.tmr = '0;
                d.tx_valid = 1'b0;
                d.pend_acc = 1'b0;
                d.acc_resp = 1'b0;
                if (q.init_cnt == `INIT_W'(`INIT_CYCLES - 1)) begin
                    d.phase = arm_pkg::ST_IDLE;
                end else begin
                    d.init_cnt = q.init_cnt + 1'b1;
                end
            end
            arm_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    d.phase = arm_pkg::ST_FRAME;
                    if (q.pend_acc) begin
                        // latch the newest sample for the response now running
                        d.acc_resp = 1'b1;
                        d.resp_axis = q.pend_axis;
                        d.tx_word[`SMP_W-1:0] = sample[q.pend_axis];
                        eval[q.pend_axis] = ~exception_flag;
                    end
                end
            end
            arm_pkg::ST_FRAME: begin
                if (cs_rise) begin
                    d.phase = arm_pkg::ST_IDLE;
                    d.acc_resp = 1'b0;
                    d.pend_acc = 1'b0;
                    d.tx_valid = 1'b1;
                    if (mismatch) begin
                        d.tx_word = `ERR_WORD;
                        d.tx_own_y = 1'b0;
                    end else if (x_rx == `CMD_RESET) begin
                        d.phase = arm_pkg::ST_INIT;
                        d.init_cnt = '0;
                        d.tx_valid = 1'b0;
                        d.cond = '0;
                        d.tmr = '0;
                    end else if (x_rx[`BIT_ACC]) begin
                        d.pend_acc = 1'b1;
                        d.pend_axis = x_rx[`BIT_AXIS];
                        d.tx_own_y = x_rx[`BIT_AXIS];
                        d.tx_word = {1'b0, x_rx[`BIT_AXIS], `ACC_HDR, {`SMP_W{1'b0}}};
                    end else begin
                        d.tx_own_y = x_rx[`ADDR_LSB];
                        d.tx_word = {x_rx[`FRAME_W-1:`ADDR_LSB], `REG_FILL};
                    end
                end
            end
            default: begin
                d.phase = arm_pkg::ST_INIT;
                d.init_cnt = '0;
            end
        endcase

        if (q.uv_sync) begin
            d.phase = arm_pkg::ST_INIT;
            d.init_cnt = '0;
        end

        // per-axis arming, stretch and pulse code
        for (int a = 0; a < `AXES; a++) begin
            if (eval[a]) begin
                d.cond[a] = unf_mode ? thr_hit(sample[a], thr[a])
                    : filt_hit[a];
            end
            if (eval[a] && d.cond[a] && filt_mode && sel[a] != `SEL_OFF) begin
                d.tmr[a] = stretch_load(sel[a]);
            end else if (tick && d.tmr[a] != '0) begin
                d.tmr[a] = d.tmr[a] - 1'b1;
            end
            if (unf_mode) begin
                active[a] = q.cond[a] & q.acc_resp & (q.resp_axis == 1'(a))
                    & ~q.cs_sync;
            end else if (sel[a] == `SEL_OFF) begin
                active[a] = q.cond[a];
            end else begin
                active[a] = (q.tmr[a] != '0);
            end
            if (pcm_strobe) begin
                {d.pcm[a], d.pcm_acc[a]} = {1'b0, q.pcm_acc[a]}
                    + {1'b0, pcm_code(sample[a])};
            end
            if (arm_field.mode == `MODE_PCM) begin
                d.pin[a] = q.pcm[a];
            end else begin
                d.pin[a] = active[a] ^ arm_field.active_low;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.cs_meta <= 1'b1;
            q.cs_sync <= 1'b1;
            q.cs_prev <= 1'b1;
            q.phase <= arm_pkg::ST_INIT;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_reset_cmd;
        q.phase == arm_pkg::ST_FRAME && cs_rise && !mismatch && x_rx == `CMD_RESET;
    endsequence

    sequence s_init_hold;
        (q.phase == arm_pkg::ST_INIT && !q.tx_valid && q.tmr == '0) [*8];
    endsequence

    AST_INIT_ENTRY: assert property (s_reset_cmd |=> s_init_hold)
        else $error("reset command did not start initialization");

    AST_INIT_EXIT: assert property (
        (q.phase == arm_pkg::ST_INIT && q.init_cnt == `INIT_W'(`INIT_CYCLES - 1) && !q.uv_sync)
        |=> q.phase == arm_pkg::ST_IDLE)
        else $error("initialization did not end on time");

    AST_STRETCH_DECR: assert property (
        (q.phase == arm_pkg::ST_IDLE && tick && q.tmr[0] != '0 && !eval[0] && !q.uv_sync)
        |=> q.tmr[0] == $past(q.tmr[0]) - 1'b1)
        else $error("stretch counter did not step down");

    AST_UNF_NO_STRETCH: assert property (
        unf_mode |=> !(q.tmr[0] > $past(q.tmr[0])))
        else $error("stretch loaded in unfiltered mode");

    AST_RELOAD: assert property (
        (eval[0] && d.cond[0] && filt_mode && sel[0] != `SEL_OFF && !q.uv_sync)
        |=> q.tmr[0] == stretch_load($past(sel[0])))
        else $error("stretch counter not loaded on arming");

    AST_EXC_NO_RELOAD: assert property (
        (exception_flag && q.tmr[0] == '0) |=> q.tmr[0] == '0)
        else $error("stretch counter loaded after exception");

    AST_SEL0_DIRECT: assert property (
        (arm_field.mode == `MODE_CNT && sel[0] == `SEL_OFF)
        |=> q.pin[0] == ($past(q.cond[0]) ^ $past(arm_field.active_low)))
        else $error("arming pin does not follow condition");

    AST_TMR_PIN: assert property (
        (filt_mode && sel[0] != `SEL_OFF)
        |=> q.pin[0] == (($past(q.tmr[0]) != '0) ^ $past(arm_field.active_low)))
        else $error("arming pin does not follow stretch timer");

    AST_UNF_PIN: assert property (
        (unf_mode && !arm_field.active_low && q.cond[0] && q.acc_resp
         && !q.resp_axis && !q.cs_sync)
        |=> q.pin[0])
        else $error("unfiltered arming pin not asserted");

    AST_MISMATCH_ERR: assert property (
        (q.phase == arm_pkg::ST_FRAME && cs_rise && mismatch && !q.uv_sync)
        |=> (q.tx_word == `ERR_WORD && !q.tx_own_y && q.tx_valid))
        else $error("mismatched frames not answered with error");

    AST_OWNER: assert property (
        (q.phase == arm_pkg::ST_FRAME && cs_rise && !mismatch && x_rx[`BIT_ACC]
         && x_rx != `CMD_RESET && !q.uv_sync)
        |=> (q.tx_own_y == $past(x_rx[`BIT_AXIS]) && q.pend_acc))
        else $error("wrong block owns the response");

    AST_REG_OWNER: assert property (
        (q.phase == arm_pkg::ST_FRAME && cs_rise && !mismatch
         && !x_rx[`BIT_ACC] && !q.uv_sync)
        |=> (q.tx_own_y == $past(x_rx[`ADDR_LSB]) && q.tx_valid
             && q.tx_word == {$past(x_rx[`FRAME_W-1:`ADDR_LSB]), `REG_FILL}))
        else $error("register reply owned by the wrong block");

    AST_ACC_LATCH: assert property (
        (q.phase == arm_pkg::ST_IDLE && cs_fall && q.pend_acc && !q.uv_sync)
        |=> q.acc_resp && q.tx_word[`SMP_W-1:0]
            == ($past(q.pend_axis) ? $past(y_sample) : $past(x_sample)))
        else $error("acceleration sample not latched at select fall");

    AST_UNF_QUIET: assert property (
        (unf_mode && q.cs_sync)
        |=> q.pin == {`AXES{$past(arm_field.active_low)}})
        else $error("unfiltered arming pin active outside a frame");

    AST_PCM_PIN: assert property (
        (arm_field.mode == `MODE_PCM) |=> q.pin == $past(q.pcm))
        else $error("pulse-code pin does not follow carry");

    AST_EXC_FREEZE: assert property (
        (exception_flag && q.phase == arm_pkg::ST_IDLE && !q.uv_sync) |=> $stable(q.cond))
        else $error("arming condition changed during exception");

    AST_TICK_GATE: assert property (
        (q.phase == arm_pkg::ST_IDLE && !tick && !eval[0] && !q.uv_sync) |=> $stable(q.tmr[0]))
        else $error("stretch counter moved between ticks");

    AST_TX_STABLE: assert property (
        (q.phase == arm_pkg::ST_FRAME && !cs_rise && !q.uv_sync)
        |=> $stable(q.tx_word) && $stable(q.tx_own_y) && $stable(q.tx_valid))
        else $error("response changed inside a frame");
endmodule

// ---- tb/spi_master_model.sv ----
/*
  serial link master: cpol 0, cpha 0, msb first, 80 ns link clock.
  assumes the slave answers on miso with miso_oe high while it drives.
*/
`timescale 1ns/100ps
module spi_master_model (
    // pins driven
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    // pins sensed
    input wire logic miso,
    input wire logic miso_oe
);
    // ----------------------------------------
    // frame and idle-line tasks
    // ----------------------------------------
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // one 16 clock frame, command out and reply in
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx, output logic oe);
        oe = 1'b1;
        #3.3;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = cmd[i];
            #40;
            rx[i] = miso;
            oe = oe & miso_oe;
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
        end
        #20;
        cs_n = 1'b1;
        mosi = ~mosi;
        #40;
    endtask

    // another slave's traffic while this select is high
    task automatic noise();
        for (int k = 0; k < 5; k++) begin
            mosi = ~mosi;
            #40;
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
        end
    endtask
endmodule

// ---- tb/tb.sv ----
/*
  testbench of the arming output stage and dual serial front.
  assumes the master model beside it and the design's shared constants.
*/
`timescale 1ns/100ps
`include "arm_consts.svh"
module tb;
    // ----------------------------------------
    // signals, instances, model
    // ----------------------------------------
    localparam int TICK = 32;
    logic sys_clk, reset_n, undervolt, sclk, cs_n, mosi, miso, miso_oe;
    arm_pkg::arm_field_t arm_field;
    arm_pkg::arm_config_t arm_config;
    arm_pkg::thresh_t x_th, y_th;
    logic [9:0] xs, ys;
    logic [1:0] filt_hit;
    logic exc, arm_x_pin, arm_y_pin, oe;
    logic [15:0] rx;
    int miscompares, checks, run, last_run, nx, ny, ex, ey;
    int pend[$];
    int lds[3] = '{`STRETCH_1, `STRETCH_2, `STRETCH_3};
    logic [15:0] cmds[9] = '{16'h0200, 16'h0300, 16'h8000, 16'hC000, 16'h7F55,
                             16'hC000, 16'h8000, 16'h0000, 16'h0000};
    logic [9:0] smp[4] = '{10'h080, 10'h07C, 10'h380, 10'h384};

    arming_output_and_spi_front #(.TICK_CYCLES(TICK)) i_arming_output_and_spi_front (
        .sys_clk(sys_clk), .reset_n(reset_n), .undervolt(undervolt), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .arm_field(arm_field),
        .arm_config(arm_config), .x_arming_thresholds(x_th), .y_arming_thresholds(y_th),
        .x_sample(xs), .y_sample(ys), .filt_hit(filt_hit), .exception_flag(exc),
        .arm_x_pin(arm_x_pin), .arm_y_pin(arm_y_pin));
    spi_master_model i_spi_master_model (
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // length of the last active run of the x pin
    always @(posedge sys_clk) begin
        if (arm_x_pin === ~arm_field.active_low) run <= run + 1;
        else begin
            if (run > 0) last_run <= run;
            run <= 0;
        end
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic hit(input logic [9:0] s);
        return $signed(s[9:2]) >= $signed(x_th.pos) || $signed(s[9:2]) <= $signed(x_th.neg);
    endfunction

    task automatic cfg(input logic [1:0] md, input logic al, input logic [1:0] sx,
                       input logic [1:0] sy);
        @(posedge sys_clk);
        #1;
        arm_field.mode = md;
        arm_field.active_low = al;
        arm_config.x_stretch_select = sx;
        arm_config.y_stretch_select = sy;
    endtask

    // one frame; the reply must answer the command before it
    task automatic frame(input logic [15:0] cmd);
        int p;
        logic [15:0] e;
        p = (pend.size() > 0) ? pend.pop_front() : -1;
        i_spi_master_model.xfer(cmd, rx, oe);
        if (p < 0) chk_pin(oe, 1'b0);
        else begin
            e = p[15] ? {1'b0, p[14], 4'h0, p[14] ? ys : xs} : {p[15:8], 8'h00};
            chk_pin(oe, 1'b1);
            chk_word(rx, e);
        end
        if (cmd != 16'hFFFF) pend.push_back(cmd);
    endtask

    initial begin
        #400000;
        miscompares++;
        stop_test();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hD8798EFD));
        reset_n = 1'b0;
        undervolt = 1'b0;
        arm_field = '{mode: `MODE_MA, active_low: 1'b1};
        arm_config = '0;
        x_th = '{pos: 8'h20, neg: 8'hE0};
        y_th = '{pos: 8'h20, neg: 8'hE0};
        xs = '0;
        ys = '0;
        filt_hit = '0;
        exc = 1'b0;
        repeat (5) @(posedge sys_clk);
        chk_pin(arm_x_pin, 1'b0);
        chk_pin(miso_oe, 1'b0);
        #1 reset_n = 1'b1;
        repeat (2010) @(posedge sys_clk);
        chk_pin(arm_y_pin, 1'b1);
        cfg(`MODE_MA, 1'b0, 2'h0, 2'h0);
        foreach (cmds[i]) begin
            @(posedge sys_clk);
            #1 xs = 10'($urandom);
            ys = 10'($urandom);
            frame(cmds[i]);
            i_spi_master_model.noise();
        end
        cfg(`MODE_UNF, 1'b0, 2'h3, 2'h3);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            #1 xs = smp[i % 4];
            ys = smp[i % 4];
            frame({1'b1, i >= 4, 14'h0000});
            fork
                frame(16'h0000);
                begin
                    #700;
                    chk_pin(arm_x_pin, hit(xs) && i < 4);
                    chk_pin(arm_y_pin, hit(ys) && i >= 4);
                end
            join
            repeat (20) @(posedge sys_clk);
            chk_pin(arm_x_pin | arm_y_pin, 1'b0);
        end
        #1 filt_hit = 2'b01;
        for (int sel = 1; sel <= 3; sel++) begin
            cfg(sel[0] ? `MODE_MA : `MODE_CNT, sel == 2, sel[1:0], 2'h0);
            repeat (5) @(posedge sys_clk);
            #1 last_run = 0;
            frame(16'h8000);
            frame(16'h0000);
            @(posedge sys_clk);
            #1 exc = (sel == 3);
            repeat (lds[sel-1] * TICK + 100) @(posedge sys_clk);
            chk_pin(last_run >= (lds[sel-1] - 1) * TICK, 1'b1);
            chk_pin(last_run <= lds[sel-1] * TICK + 8, 1'b1);
            chk_pin(arm_x_pin, sel == 2);
        end
        frame(16'h8000);
        frame(16'h0000);
        repeat (100) @(posedge sys_clk);
        chk_pin(arm_x_pin, 1'b0);
        cfg(`MODE_CNT, 1'b0, 2'h0, 2'h0);
        exc = 1'b0;
        filt_hit = 2'b10;
        frame(16'hC000);
        frame(16'h0000);
        repeat (600) @(posedge sys_clk);
        chk_pin(arm_y_pin, 1'b1);
        #1 filt_hit = 2'b00;
        frame(16'hC000);
        frame(16'h0000);
        repeat (10) @(posedge sys_clk);
        chk_pin(arm_y_pin, 1'b0);
        cfg(`MODE_PCM, 1'b0, 2'h0, 2'h0);
        xs = 10'($urandom);
        ys = 10'($urandom);
        ex = 25 * {~xs[9], xs[8:1]};
        ey = 25 * {~ys[9], ys[8:1]};
        repeat (300) @(posedge sys_clk);
        repeat (12800) begin
            @(posedge sys_clk);
            if (arm_x_pin === 1'b1) nx++;
            if (arm_y_pin === 1'b1) ny++;
        end
        chk_word(nx[15:0], ex[15:0]);
        chk_word(ny[15:0], ey[15:0]);
        cfg(`MODE_MA, 1'b0, 2'h0, 2'h0);
        frame(16'hFFFF);
        repeat (2010) @(posedge sys_clk);
        chk_pin(arm_x_pin, 1'b0);
        #1 undervolt = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 undervolt = 1'b0;
        repeat (2010) @(posedge sys_clk);
        frame(16'h0300);
        frame(16'h0200);
        stop_test();
    end
endmodule
